/* File: design/tcp_timer16.sv */
// Top: one 16-bit timer half with capture, PWM and AHB-Lite registers
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module tcp_timer16
  import tcp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic capture_compare_pin_in,
  output logic capture_compare_pin_out,
  output logic capture_compare_pin_oen,
  output logic trigger_out,
  output logic irq
);
  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic timer_run_enable;
  logic stall_freeze_bit;
  logic [1:0] edge_select_field;
  logic trigger_output_enable;
  logic pwm_output_invert;
  logic [1:0] timer_mode_field;
  logic capture_mode_select;
  logic alternate_mode_select;
  logic [15:0] interval_load_value;
  logic [15:0] match_value;
  logic [7:0] prescale_value;
  logic [2:0] interrupt_mask_setting;
  logic [2:0] raw_status_flags;
  logic [15:0] count;
  logic [7:0] presc_cnt;
  logic [15:0] captured_count_value;
  logic pwm_level;
  logic trig;
  logic load_wr;
  logic [7:0] a_addr;
  logic a_wr;
  logic a_valid;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic is_pwm;
  logic is_ecount;
  logic is_etime;
  logic is_timer;
  logic sel_edge;
  logic step;
  logic at_zero;
  logic timeout_ev;
  logic match_ev;
  logic capt_ev;
  logic clr_wr;
  logic [2:0] clr_bits;
  logic [2:0] set_bits;
  logic ctl_wr;

  tcp_edge_if edges ();

  tcp_edge_det u_det (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(capture_compare_pin_in),
    .edge_o(edges)
  );

  assign is_pwm = alternate_mode_select && !capture_mode_select
                  && (timer_mode_field == TCP_MR_PERIODIC);
  assign is_ecount = !alternate_mode_select && (timer_mode_field == TCP_MR_CAPTURE)
                     && !capture_mode_select;
  assign is_etime = !alternate_mode_select && (timer_mode_field == TCP_MR_CAPTURE)
                    && capture_mode_select;
  assign is_timer = !alternate_mode_select
                    && (timer_mode_field == TCP_MR_ONESHOT || timer_mode_field == TCP_MR_PERIODIC);

  always_comb begin
    unique case (edge_select_field)
      TCP_EDGE_RISE: sel_edge = edges.rise;
      TCP_EDGE_FALL: sel_edge = edges.fall;
      TCP_EDGE_BOTH: sel_edge = edges.rise || edges.fall;
      default: sel_edge = 1'b0;
    endcase
  end

  // Prescaler only for timer and PWM modes
  assign step = timer_run_enable && !stall_freeze_bit
                && (is_etime || presc_cnt == TCP_PRESC_RST);
  assign at_zero = (count == TCP_COUNT_ZERO);
  assign timeout_ev = is_timer && step && at_zero;
  assign match_ev = is_ecount && timer_run_enable && !stall_freeze_bit
                    && sel_edge && (count - 16'h0001 == match_value);
  assign capt_ev = is_etime && timer_run_enable && sel_edge;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_valid <= 1'b0;
      a_wr <= 1'b0;
      a_addr <= 8'h00;
    end else if (hready) begin
      a_valid <= hsel && htrans[1];
      a_wr <= hwrite;
      a_addr <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ctl_wr = a_valid && a_wr && (a_addr == TCP_OFS_CTL);
  assign load_wr = a_valid && a_wr && (a_addr == TCP_OFS_LOAD);
  assign clr_wr = a_valid && a_wr && (a_addr == TCP_OFS_CLR);
  assign clr_bits = clr_wr ? hwdata[2:0] : 3'h0;

  always_comb begin
    hrdata = 32'h0000_0000;
    if (a_valid && !a_wr) begin
      unique case (a_addr)
        TCP_OFS_CTL: hrdata = {25'h0, pwm_output_invert, trigger_output_enable, 1'b0,
                               edge_select_field, stall_freeze_bit, timer_run_enable};
        TCP_OFS_MODE: hrdata = {28'h0, alternate_mode_select, capture_mode_select, timer_mode_field};
        TCP_OFS_LOAD: hrdata = {16'h0, interval_load_value};
        TCP_OFS_MATCH: hrdata = {16'h0, match_value};
        TCP_OFS_PRESC: hrdata = {24'h0, prescale_value};
        TCP_OFS_MASK: hrdata = {29'h0, interrupt_mask_setting};
        TCP_OFS_RAW: hrdata = {29'h0, raw_status_flags};
        TCP_OFS_MIS: hrdata = {29'h0, raw_status_flags & interrupt_mask_setting};
        TCP_OFS_COUNT: hrdata = {16'h0, count};
        TCP_OFS_CAPT: hrdata = {16'h0, captured_count_value};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_freeze_bit <= 1'b0;
      edge_select_field <= TCP_EDGE_RISE;
      trigger_output_enable <= 1'b0;
      pwm_output_invert <= 1'b0;
      timer_mode_field <= 2'h0;
      capture_mode_select <= 1'b0;
      alternate_mode_select <= 1'b0;
      match_value <= 16'h0000;
      prescale_value <= TCP_PRESC_RST;
      interrupt_mask_setting <= 3'h0;
      interval_load_value <= TCP_LOAD_RST;
    end else if (a_valid && a_wr) begin
      unique case (a_addr)
        TCP_OFS_CTL: begin
          stall_freeze_bit <= hwdata[TCP_CTL_STALL];
          edge_select_field <= hwdata[TCP_CTL_EDGE_LO +: 2];
          trigger_output_enable <= hwdata[TCP_CTL_OTE];
          pwm_output_invert <= hwdata[TCP_CTL_INV];
        end
        TCP_OFS_MODE: begin
          timer_mode_field <= hwdata[1:0];
          capture_mode_select <= hwdata[TCP_MODE_CMR];
          alternate_mode_select <= hwdata[TCP_MODE_AMS];
        end
        TCP_OFS_LOAD: interval_load_value <= hwdata[15:0];
        TCP_OFS_MATCH: match_value <= hwdata[15:0];
        TCP_OFS_PRESC: prescale_value <= hwdata[7:0];
        TCP_OFS_MASK: interrupt_mask_setting <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Run enable
  // ----------------------------------------------------------------
  // Hardware stop wins over a same-cycle software set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_run_enable <= 1'b0;
    end else if ((timeout_ev && timer_mode_field == TCP_MR_ONESHOT) || match_ev) begin
      timer_run_enable <= 1'b0;
    end else if (ctl_wr) begin
      timer_run_enable <= hwdata[TCP_CTL_EN];
    end
  end

  // ----------------------------------------------------------------
  // Counter and prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= TCP_LOAD_RST;
    end else if (load_wr) begin
      count <= hwdata[15:0];
    end else if (match_ev) begin
      count <= interval_load_value;
    end else if (is_ecount) begin
      if (timer_run_enable && !stall_freeze_bit && sel_edge) begin
        count <= count - 16'h0001;
      end
    end else if (step) begin
      if (at_zero) begin
        count <= interval_load_value;
      end else begin
        count <= count - 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_cnt <= TCP_PRESC_RST;
    end else if (timer_run_enable && !stall_freeze_bit && !is_etime && !is_ecount) begin
      if (presc_cnt == TCP_PRESC_RST) begin
        presc_cnt <= prescale_value;
      end else begin
        presc_cnt <= presc_cnt - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, capture, trigger, PWM
  // ----------------------------------------------------------------
  assign set_bits = {capt_ev, match_ev, timeout_ev};

  // Set wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_status_flags <= 3'h0;
    end else begin
      raw_status_flags <= (raw_status_flags & ~clr_bits) | set_bits;
    end
  end

  assign irq = |(raw_status_flags & interrupt_mask_setting);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      captured_count_value <= 16'h0000;
    end else if (capt_ev) begin
      captured_count_value <= count;
    end
  end

  // Only the counting step at zero fires, not the prescaler wait at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig <= 1'b0;
    end else begin
      trig <= trigger_output_enable && step
              && at_zero && (is_timer || is_pwm) && !trig;
    end
  end
  assign trigger_out = trig;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_level <= 1'b0;
    end else if (!is_pwm) begin
      pwm_level <= 1'b0;
    end else if (count == interval_load_value) begin
      pwm_level <= 1'b1;
    end else if (count == match_value) begin
      pwm_level <= 1'b0;
    end
  end

  assign capture_compare_pin_out = pwm_level ^ pwm_output_invert;
  assign capture_compare_pin_oen = !is_pwm;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_oneshot_stops: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout_ev && timer_mode_field == TCP_MR_ONESHOT) |=> !timer_run_enable)
    else $error("one-shot did not stop");
  a_zero_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    (step && at_zero && !load_wr && !is_ecount) |=> count == $past(interval_load_value))
    else $error("no reload at zero");
  a_timeout_raw: assert property (@(posedge hclk) disable iff (!hresetn)
    timeout_ev |=> raw_status_flags[TCP_FLG_TO])
    else $error("timeout flag missing");
  a_match_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    match_ev |=> !timer_run_enable && raw_status_flags[TCP_FLG_CM])
    else $error("match not handled");
  a_trig_width: assert property (@(posedge hclk) disable iff (!hresetn)
    trig |=> !trig)
    else $error("trigger wider than one cycle");
  a_stall_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (stall_freeze_bit && !load_wr && !match_ev) |=> $stable(count))
    else $error("count moved in stall");
  a_capture_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    capt_ev |=> captured_count_value == $past(count) && raw_status_flags[TCP_FLG_CE])
    else $error("capture wrong");
  a_pwm_noflag: assert property (@(posedge hclk) disable iff (!hresetn)
    is_pwm |-> set_bits == 3'h0)
    else $error("flag in pwm mode");
  a_trig_on_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (trigger_output_enable && step && at_zero && (is_timer || is_pwm) && !trig) |=> trig)
    else $error("trigger missed at zero");
  a_load_write: assert property (@(posedge hclk) disable iff (!hresetn)
    load_wr |=> count == interval_load_value)
    else $error("load write not taken");
  a_step_down: assert property (@(posedge hclk) disable iff (!hresetn)
    (step && !at_zero && !load_wr && !is_ecount) |=> count == $past(count) - 16'h0001)
    else $error("count did not step down");
  a_periodic_runs: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout_ev && timer_mode_field == TCP_MR_PERIODIC && !ctl_wr) |=> timer_run_enable)
    else $error("periodic stopped at timeout");
  a_ecount_decr: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_ecount && timer_run_enable && !stall_freeze_bit && sel_edge && !load_wr && !match_ev)
    |=> count == $past(count) - 16'h0001)
    else $error("edge not counted");
  a_match_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_ecount && !timer_run_enable && !load_wr) |=> $stable(count))
    else $error("edge counted while stopped");
  a_etime_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_etime && timer_run_enable && !stall_freeze_bit && !at_zero && !load_wr)
    |=> count == $past(count) - 16'h0001)
    else $error("edge time count not free-running");
  a_capture_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !capt_ev |=> $stable(captured_count_value))
    else $error("capture changed without edge");
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (raw_status_flags[TCP_FLG_TO] && !clr_bits[TCP_FLG_TO]) |=> raw_status_flags[TCP_FLG_TO])
    else $error("timeout flag lost");
  a_timeout_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout_ev && interrupt_mask_setting[TCP_FLG_TO]) |=> irq || !interrupt_mask_setting[TCP_FLG_TO])
    else $error("unmasked timeout without irq");
  a_pwm_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_pwm && count == interval_load_value) |=> pwm_level)
    else $error("pwm not high at load");
  a_pwm_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    (is_pwm && count == match_value && count != interval_load_value) |=> !pwm_level)
    else $error("pwm not low at match");
endmodule // tcp_timer16

/* File: include/tcp_pkg.sv */
// Package: constants, register map and encodings of the 16-bit capture/PWM timer
// Function
// - Run enable starts down count from preload
// - At zero, reload interval and prescale next
// - One-shot stops, clears run enable; periodic continues
// - Zero sets sticky timeout raw flag
// - Unmasked timeout sets masked flag, interrupt
// - Trigger pulse one cycle at zero
// - Interval load write while running reloads counter
// - Stall bit freezes the count
// - Prescaler gives prescale plus one clocks
// - Capture mode zero selects edge count
// - Each selected edge decrements until match
// - Match sets count match raw, masked flags
// - After match reload, clear run, ignore edges
// - Edge time free-runs from load, no prescale
// - Capture mode one selects edge time
// - Edge copies count to capture, sets flag
// - Edge time keeps counting, reloads at zero
// - PWM counts down, reloads, repeats while enabled
// - PWM mode raises no flags or interrupt
// - PWM high at load, low at match
// - Invert bit inverts PWM output
package tcp_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TCP_OFS_CTL = 8'h00;
  localparam logic [7:0] TCP_OFS_MODE = 8'h04;
  localparam logic [7:0] TCP_OFS_LOAD = 8'h08;
  localparam logic [7:0] TCP_OFS_MATCH = 8'h0C;
  localparam logic [7:0] TCP_OFS_PRESC = 8'h10;
  localparam logic [7:0] TCP_OFS_MASK = 8'h14;
  localparam logic [7:0] TCP_OFS_RAW = 8'h18;
  localparam logic [7:0] TCP_OFS_MIS = 8'h1C;
  localparam logic [7:0] TCP_OFS_CLR = 8'h20;
  localparam logic [7:0] TCP_OFS_COUNT = 8'h24;
  localparam logic [7:0] TCP_OFS_CAPT = 8'h28;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TCP_CTL_EN = 0;
  localparam int TCP_CTL_STALL = 1;
  localparam int TCP_CTL_EDGE_LO = 2;
  localparam int TCP_CTL_OTE = 5;
  localparam int TCP_CTL_INV = 6;
  localparam int TCP_MODE_CMR = 2;
  localparam int TCP_MODE_AMS = 3;
  localparam int TCP_FLG_TO = 0;
  localparam int TCP_FLG_CM = 1;
  localparam int TCP_FLG_CE = 2;
  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] TCP_MR_ONESHOT = 2'h1;
  localparam logic [1:0] TCP_MR_PERIODIC = 2'h2;
  localparam logic [1:0] TCP_MR_CAPTURE = 2'h3;
  localparam logic [1:0] TCP_EDGE_RISE = 2'h0;
  localparam logic [1:0] TCP_EDGE_FALL = 2'h1;
  localparam logic [1:0] TCP_EDGE_BOTH = 2'h3;
  localparam logic [15:0] TCP_LOAD_RST = 16'hFFFF;
  localparam logic [15:0] TCP_COUNT_ZERO = 16'h0000;
  localparam logic [7:0] TCP_PRESC_RST = 8'h00;
  localparam logic [2:0] TCP_SYNC_RST = 3'h0;
endpackage

/* File: include/tcp_edge_if.sv */
// Interface: synchronised pin edges between detector and timer core
`timescale 1ns/1ps
interface tcp_edge_if;
  logic pin_level;
  logic rise;
  logic fall;
  modport det (output pin_level, output rise, output fall);
  modport core (input pin_level, input rise, input fall);
endinterface

/* File: design/tcp_edge_det.sv */
// Pin synchroniser and edge detector for the capture/compare pin
`timescale 1ns/1ps
module tcp_edge_det
  import tcp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  tcp_edge_if.det edge_o
);
  logic [2:0] sync;
  logic stable;

  // First stage is read only by the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync <= TCP_SYNC_RST;
    end else begin
      sync <= {sync[1:0], pin_in};
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stable <= 1'b0;
    end else if (sync[1] == sync[2]) begin
      stable <= sync[2];
    end
  end

  assign edge_o.pin_level = stable;
  assign edge_o.rise = (sync[1] == sync[2]) && sync[2] && !stable;
  assign edge_o.fall = (sync[1] == sync[2]) && !sync[2] && stable;
endmodule // tcp_edge_det

/* File: bench/tcp_pin_model.sv */
// Far-side model: external signal source on the capture/compare pin
`timescale 1ns/1ps
module tcp_pin_model (
  input wire logic hclk,
  input wire logic pin_out,
  input wire logic pin_oen,
  output logic pin_in
);
  // ----------------------------------------------------------------
  // Wire level
  // ----------------------------------------------------------------
  logic level;
  initial level = 1'b0;
  // Timer drives only while its enable is low
  assign pin_in = pin_oen ? level : pin_out;
  // ----------------------------------------------------------------
  // Edge source
  // ----------------------------------------------------------------
  // Eight cycles per level, well over the synchroniser's two-cycle minimum
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (8) @(posedge hclk);
      level <= ~level;
    end
    repeat (8) @(posedge hclk);
  endtask
endmodule // tcp_pin_model

/* File: bench/tb_top.sv */
// Testbench: register-level tests of the 16-bit capture/PWM timer
`timescale 1ns/1ps
module tb_top;
  import tcp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin_in, pin_out, pin_oen, trigger_out, irq;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_trig = 0;
  int wide_trig = 0;
  int last_trig = 0;
  int trig_per = 0;
  int pwm_hi = 0;
  logic pwm_win = 1'b0;
  logic prev_trig = 1'b0;
  logic [31:0] va, vb;
  always #2 hclk = ~hclk;
  tcp_timer16 DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_compare_pin_in(pin_in),
    .capture_compare_pin_out(pin_out), .capture_compare_pin_oen(pin_oen),
    .trigger_out(trigger_out), .irq(irq));
  tcp_pin_model u_pin (.hclk(hclk), .pin_out(pin_out), .pin_oen(pin_oen), .pin_in(pin_in));
  // ----------------------------------------------------------------
  // Monitors and timeout
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    prev_trig <= trigger_out;
    if (trigger_out === 1'b1) begin
      n_trig <= n_trig + 1;
      trig_per <= cyc - last_trig;
      last_trig <= cyc;
      if (prev_trig === 1'b1) wide_trig <= wide_trig + 1;
    end
    if (pwm_win && pin_out === 1'b1) pwm_hi <= pwm_hi + 1;
    if (cyc > 40000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  // Address phase held until hready, data phase until hready again
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0, v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] p;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rc(TCP_OFS_LOAD, 32'h0000FFFF);
    rc(TCP_OFS_COUNT, 32'h0000FFFF);
    rc(TCP_OFS_PRESC, 32'h0);
    rc(TCP_OFS_CTL, 32'h0);
    rc(TCP_OFS_RAW, 32'h0);
    rc(8'h3C, 32'h0);
    chk({29'h0, pin_oen, hresp, hreadyout}, 32'h5);
    // One-shot with trigger and unmasked timeout
    wr(TCP_OFS_MODE, 32'h1);
    wr(TCP_OFS_LOAD, 32'h14);
    wr(TCP_OFS_MASK, 32'h1);
    wr(TCP_OFS_CTL, 32'h21);
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge hclk);
    repeat (30) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    rc(TCP_OFS_CTL, 32'h20);
    rc(TCP_OFS_COUNT, 32'h14);
    rc(TCP_OFS_RAW, 32'h1);
    rc(TCP_OFS_MIS, 32'h1);
    chk(n_trig, 32'h1);
    chk(wide_trig, 32'h0);
    wr(TCP_OFS_CLR, 32'h1);
    rc(TCP_OFS_RAW, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Periodic: trigger spacing is (load+1)*(prescale+1)
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 8'h00 : ((k == 1) ? 8'h01 : 8'hFF);
      wr(TCP_OFS_CTL, 32'h0);
      wr(TCP_OFS_PRESC, {24'h0, p});
      wr(TCP_OFS_LOAD, 32'h3);
      wr(TCP_OFS_MODE, 32'h2);
      wr(TCP_OFS_CTL, 32'h21);
      repeat (12 * (p + 1) + 20) @(posedge hclk);
      chk(trig_per, 4 * (p + 1));
    end
    // Live load write, then stall
    wr(TCP_OFS_PRESC, 32'h0);
    wr(TCP_OFS_LOAD, 32'h1000);
    repeat (300) @(posedge hclk);
    rd(TCP_OFS_COUNT, va);
    chk({31'h0, va <= 32'h1000 && va > 32'hE00}, 32'h1);
    wr(TCP_OFS_CTL, 32'h23);
    rd(TCP_OFS_COUNT, va);
    repeat (20) @(posedge hclk);
    rc(TCP_OFS_COUNT, va);
    wr(TCP_OFS_CTL, 32'h21);
    repeat (20) @(posedge hclk);
    rd(TCP_OFS_COUNT, vb);
    chk({31'h0, vb < va}, 32'h1);
    // Edge count, both edges: load 10, match 6 counts four
    wr(TCP_OFS_CTL, 32'h0);
    wr(TCP_OFS_MODE, 32'h3);
    wr(TCP_OFS_LOAD, 32'hA);
    wr(TCP_OFS_MATCH, 32'h6);
    wr(TCP_OFS_MASK, 32'h2);
    wr(TCP_OFS_CLR, 32'h7);
    wr(TCP_OFS_CTL, 32'hD);
    u_pin.toggle(3);
    rc(TCP_OFS_COUNT, 32'h7);
    u_pin.toggle(3);
    rc(TCP_OFS_RAW, 32'h2);
    rc(TCP_OFS_MIS, 32'h2);
    rc(TCP_OFS_CTL, 32'hC);
    rc(TCP_OFS_COUNT, 32'hA);
    // Edge time, rising then falling edge, prescaler left at its largest value
    wr(TCP_OFS_CLR, 32'h7);
    wr(TCP_OFS_PRESC, 32'hFF);
    wr(TCP_OFS_LOAD, 32'hFFFF);
    wr(TCP_OFS_MODE, 32'h7);
    wr(TCP_OFS_MASK, 32'h4);
    wr(TCP_OFS_CTL, 32'h1);
    repeat (20) @(posedge hclk);
    rd(TCP_OFS_COUNT, va);
    u_pin.toggle(1);
    rd(TCP_OFS_CAPT, vb);
    chk({31'h0, (va - vb) >= 32'h8 && (va - vb) <= 32'h1E}, 32'h1);
    rc(TCP_OFS_RAW, 32'h4);
    rc(TCP_OFS_MIS, 32'h4);
    u_pin.toggle(1);
    rc(TCP_OFS_CAPT, vb);
    rd(TCP_OFS_COUNT, va);
    chk({31'h0, va < vb}, 32'h1);
    wr(TCP_OFS_CLR, 32'h4);
    wr(TCP_OFS_CTL, 32'h5);
    u_pin.toggle(1);
    rc(TCP_OFS_RAW, 32'h0);
    u_pin.toggle(1);
    rc(TCP_OFS_RAW, 32'h4);
    // PWM: load 20, match 5 gives 15 high of every 21 cycles
    wr(TCP_OFS_CTL, 32'h0);
    wr(TCP_OFS_CLR, 32'h7);
    wr(TCP_OFS_PRESC, 32'h0);
    wr(TCP_OFS_MODE, 32'hA);
    wr(TCP_OFS_LOAD, 32'h14);
    wr(TCP_OFS_MATCH, 32'h5);
    wr(TCP_OFS_MASK, 32'h7);
    for (int inv = 0; inv < 2; inv++) begin
      wr(TCP_OFS_CTL, inv ? 32'h41 : 32'h1);
      repeat (40) @(posedge hclk);
      pwm_hi = 0;
      pwm_win <= 1'b1;
      repeat (84) @(posedge hclk);
      pwm_win <= 1'b0;
      @(posedge hclk);
      chk(pwm_hi, inv ? 32'd24 : 32'd60);
      chk({31'h0, pin_oen}, 32'h0);
    end
    rc(TCP_OFS_RAW, 32'h0);
    chk({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule // tb_top
